// *** design/drc_core.sv ***
// frequency reference selection, direction handling, length and count counters
`timescale 1ns/1ns
module drc_core
  import drc_pkg::*;
#(
  parameter int WINDOW_CYC = RATE_WINDOW_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_DI-1:0] digital_input_terminal_i,
  input wire logic signed [15:0] reg_unit_a_i,
  input wire logic signed [15:0] reg_unit_b_i,
  input wire logic reg_dev_large_i,
  output logic [NUM_DO-1:0] digital_output_terminal_o,
  output drc_ref_t ref_o
);

  // byte-lane merge for every writable register
  function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b+:8] = dat[8*b+:8];
      end
    end
    return r;
  endfunction

  // which terminals carry a given function code
  function automatic logic [NUM_DI-1:0] di_fn_mask(input logic [8*NUM_DI-1:0] map, input logic [7:0] code);
    logic [NUM_DI-1:0] m;
    m = '0;
    for (int t = 0; t < NUM_DI; t++) begin
      m[t] = (map[8*t+:8] == code);
    end
    return m;
  endfunction

  drc_ctrl_t ctrl_reg;
  logic [15:0] maxf_reg, digf_reg, commf_reg, set_len_reg, ppm_reg, set_cnt_reg, dsg_cnt_reg;
  logic [31:0] curve_x_reg, curve_y_reg, di_lo_reg, di_hi_reg, do_map_reg;
  logic [15:0] table_reg [16];
  logic [15:0] count_reg, act_len_reg, rate_reg, rate_acc_reg;
  logic [31:0] len_pulses_reg;
  logic ack_reg;
  logic [31:0] dat_reg, rd_next;
  logic wr_hit, cnt_clr_sw, len_clr_sw, count_wr;
  logic [8*NUM_DI-1:0] di_map;

  assign di_map = {di_hi_reg, di_lo_reg};
  assign wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg;
  assign cnt_clr_sw = wr_hit & (wb_adr_i == OFS_CTRL) & wb_sel_i[1] & wb_dat_i[CTRL_CNT_CLR_BIT];
  assign len_clr_sw = wr_hit & (wb_adr_i == OFS_CTRL) & wb_sel_i[1] & wb_dat_i[CTRL_LEN_CLR_BIT];
  assign count_wr = wr_hit & (wb_adr_i == OFS_COUNT);

  // bus answer: one wait state, ack drops the cycle after it rose
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= RST_ZERO;
    end else begin
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
      dat_reg <= rd_next;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // configuration writes; reverse inhibit resets to permitted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= '0;
      maxf_reg <= RST_MAXF;
      digf_reg <= RST_ZERO[15:0];
      commf_reg <= RST_ZERO[15:0];
      curve_x_reg <= RST_CURVE_X;
      curve_y_reg <= RST_CURVE_Y;
      set_len_reg <= RST_ZERO[15:0];
      ppm_reg <= RST_PPM;
      set_cnt_reg <= RST_ZERO[15:0];
      dsg_cnt_reg <= RST_ZERO[15:0];
      di_lo_reg <= RST_ZERO;
      di_hi_reg <= RST_ZERO;
      do_map_reg <= RST_ZERO;
    end else if (wr_hit) begin
      unique case (wb_adr_i)
        OFS_CTRL: ctrl_reg <= drc_ctrl_t'(9'(wb_merge({23'h0, ctrl_reg}, wb_dat_i, wb_sel_i)));
        OFS_MAXF: maxf_reg <= 16'(wb_merge({16'h0, maxf_reg}, wb_dat_i, wb_sel_i));
        OFS_DIGF: digf_reg <= 16'(wb_merge({16'h0, digf_reg}, wb_dat_i, wb_sel_i));
        OFS_COMMF: commf_reg <= 16'(wb_merge({16'h0, commf_reg}, wb_dat_i, wb_sel_i));
        OFS_CURVE_X: curve_x_reg <= wb_merge(curve_x_reg, wb_dat_i, wb_sel_i);
        OFS_CURVE_Y: curve_y_reg <= wb_merge(curve_y_reg, wb_dat_i, wb_sel_i);
        OFS_SET_LEN: set_len_reg <= 16'(wb_merge({16'h0, set_len_reg}, wb_dat_i, wb_sel_i));
        OFS_PPM: ppm_reg <= 16'(wb_merge({16'h0, ppm_reg}, wb_dat_i, wb_sel_i));
        OFS_SET_CNT: set_cnt_reg <= 16'(wb_merge({16'h0, set_cnt_reg}, wb_dat_i, wb_sel_i));
        OFS_DSG_CNT: dsg_cnt_reg <= 16'(wb_merge({16'h0, dsg_cnt_reg}, wb_dat_i, wb_sel_i));
        OFS_DI_LO: di_lo_reg <= wb_merge(di_lo_reg, wb_dat_i, wb_sel_i);
        OFS_DI_HI: di_hi_reg <= wb_merge(di_hi_reg, wb_dat_i, wb_sel_i);
        OFS_DO_MAP: do_map_reg <= wb_merge(do_map_reg, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // preset table, sixteen signed fractions of maximum frequency
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < 16; k++) begin
        table_reg[k] <= RST_ZERO[15:0];
      end
    end else if (wr_hit && wb_adr_i[7:6] == OFS_TABLE_HI) begin
      table_reg[wb_adr_i[5:2]] <= 16'(wb_merge({16'h0, table_reg[wb_adr_i[5:2]]}, wb_dat_i, wb_sel_i));
    end
  end

  // terminal synchronisers: a level counts once stages two and three agree
  logic [NUM_DI-1:0] s1_reg, s2_reg, s3_reg, lvl_reg, lvl_d_reg;
  genvar gt;
  generate
    for (gt = 0; gt < NUM_DI; gt++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1_reg[gt] <= 1'b0;
          s2_reg[gt] <= 1'b0;
          s3_reg[gt] <= 1'b0;
          lvl_reg[gt] <= 1'b0;
          lvl_d_reg[gt] <= 1'b0;
        end else begin
          s1_reg[gt] <= digital_input_terminal_i[gt];
          s2_reg[gt] <= s1_reg[gt];
          s3_reg[gt] <= s2_reg[gt];
          if (s2_reg[gt] == s3_reg[gt]) begin
            lvl_reg[gt] <= s3_reg[gt];
          end
          lvl_d_reg[gt] <= lvl_reg[gt];
        end
      end
    end
  endgenerate

  logic pulse_rise, len_edge, cnt_lvl, cnt_lvl_d_reg, cnt_edge, len_clr_di, cnt_clr_di, unit_b;
  logic [3:0] mspd_idx;
  // only the pulse terminal may feed the rate and the length count
  assign pulse_rise = lvl_reg[PULSE_DI] & ~lvl_d_reg[PULSE_DI];
  assign len_edge = pulse_rise & (di_map[8*PULSE_DI+:8] == FN_LEN_IN);
  assign cnt_lvl = |(lvl_reg & di_fn_mask(di_map, FN_CNT_IN));
  assign cnt_edge = cnt_lvl & ~cnt_lvl_d_reg;
  assign len_clr_di = |(lvl_reg & di_fn_mask(di_map, FN_LEN_CLR));
  assign cnt_clr_di = |(lvl_reg & di_fn_mask(di_map, FN_CNT_CLR));
  assign unit_b = ctrl_reg.regulator_auto ? reg_dev_large_i : |(lvl_reg & di_fn_mask(di_map, FN_UNIT_SW));

  // select bits: terminal with no code contributes zero
  generate
    for (gt = 0; gt < 4; gt++) begin : g_mspd
      assign mspd_idx[gt] = |(lvl_reg & di_fn_mask(di_map, FN_MSPD0 + 8'(gt)));
    end
  endgenerate

  // pulse rate: rising edges per fixed window, 1000 at full rate
  logic [17:0] win_cnt_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_cnt_reg <= '0;
      rate_acc_reg <= '0;
      rate_reg <= '0;
      cnt_lvl_d_reg <= 1'b0;
    end else begin
      cnt_lvl_d_reg <= cnt_lvl;
      if (win_cnt_reg == 18'(WINDOW_CYC - 1)) begin
        win_cnt_reg <= '0;
        rate_reg <= rate_acc_reg + 16'(pulse_rise);
        rate_acc_reg <= '0;
      end else begin
        win_cnt_reg <= win_cnt_reg + 18'h1;
        rate_acc_reg <= rate_acc_reg + 16'(pulse_rise);
      end
    end
  end

  // shared serial divider: alternates pulse curve and length jobs
  drc_div_state_t dv_state_reg;
  logic dv_job_reg;
  logic [4:0] dv_cnt_reg;
  logic [31:0] dv_quo_reg;
  logic [16:0] dv_rem_reg, dv_rem_sh;
  logic [15:0] dv_den_reg, pulse_frac_reg;
  logic [15:0] cx1, cx2, cxc, cdx, cdy_mag;
  logic signed [15:0] cy1, cy2;
  logic cdy_neg;
  assign cx1 = curve_x_reg[15:0];
  assign cx2 = curve_x_reg[31:16];
  assign cy1 = curve_y_reg[15:0];
  assign cy2 = curve_y_reg[31:16];
  assign cxc = (rate_reg <= cx1) ? cx1 : ((rate_reg >= cx2) ? cx2 : rate_reg);
  assign cdx = (cx2 > cx1) ? (cx2 - cx1) : 16'h0001;
  assign cdy_neg = cy2 < cy1;
  assign cdy_mag = cdy_neg ? 16'(cy1 - cy2) : 16'(cy2 - cy1);
  assign dv_rem_sh = {dv_rem_reg[15:0], dv_quo_reg[31]};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dv_state_reg <= DV_IDLE;
      dv_job_reg <= 1'b0;
      dv_cnt_reg <= '0;
      dv_quo_reg <= '0;
      dv_rem_reg <= '0;
      dv_den_reg <= 16'h0001;
      pulse_frac_reg <= '0;
      act_len_reg <= '0;
    end else begin
      unique case (dv_state_reg)
        DV_IDLE: begin
          dv_cnt_reg <= '0;
          dv_rem_reg <= '0;
          if (dv_job_reg) begin
            dv_quo_reg <= len_pulses_reg;
            dv_den_reg <= (ppm_reg == 16'h0) ? 16'h0001 : ppm_reg;
          end else begin
            dv_quo_reg <= (cxc - cx1) * cdy_mag;
            dv_den_reg <= cdx;
          end
          dv_state_reg <= DV_RUN;
        end
        DV_RUN: begin
          if (dv_rem_sh >= {1'b0, dv_den_reg}) begin
            dv_rem_reg <= dv_rem_sh - {1'b0, dv_den_reg};
            dv_quo_reg <= {dv_quo_reg[30:0], 1'b1};
          end else begin
            dv_rem_reg <= dv_rem_sh;
            dv_quo_reg <= {dv_quo_reg[30:0], 1'b0};
          end
          dv_cnt_reg <= dv_cnt_reg + 5'h1;
          if (dv_cnt_reg == 5'h1f) begin
            dv_state_reg <= DV_STORE;
          end
        end
        DV_STORE: begin
          // length saturates rather than wrapping past the register width
          if (dv_job_reg) begin
            act_len_reg <= (dv_quo_reg[31:16] != 16'h0) ? 16'hffff : dv_quo_reg[15:0];
          end else begin
            pulse_frac_reg <= cdy_neg ? 16'(cy1 - $signed(dv_quo_reg[15:0])) : 16'(cy1 + $signed(dv_quo_reg[15:0]));
          end
          dv_job_reg <= ~dv_job_reg;
          dv_state_reg <= DV_IDLE;
        end
      endcase
    end
  end

  // length pulses: up only, cleared by terminal or software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      len_pulses_reg <= '0;
    end else if (len_clr_di | len_clr_sw) begin
      len_pulses_reg <= '0;
    end else if (len_edge && len_pulses_reg != 32'hffff_ffff) begin
      len_pulses_reg <= len_pulses_reg + 32'h1;
    end
  end

  // count value: no run gating; halts at set value until cleared
  logic set_hit, dsg_hit, len_hit;
  assign set_hit = (set_cnt_reg != 16'h0) && (count_reg >= set_cnt_reg);
  assign dsg_hit = (dsg_cnt_reg != 16'h0) && (count_reg >= dsg_cnt_reg);
  assign len_hit = act_len_reg > set_len_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= '0;
    end else if (count_wr) begin
      count_reg <= 16'(wb_merge({16'h0, count_reg}, wb_dat_i, wb_sel_i));
    end else if (cnt_clr_di | cnt_clr_sw) begin
      count_reg <= '0;
    end else if (cnt_edge && !set_hit) begin
      count_reg <= count_reg + 16'h1;
    end
  end

  // output terminals follow their mapped function codes
  generate
    for (gt = 0; gt < NUM_DO; gt++) begin : g_do
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          digital_output_terminal_o[gt] <= 1'b0;
        end else begin
          digital_output_terminal_o[gt] <= ((do_map_reg[8*gt+:8] == FO_SET_CNT) & set_hit)
            | ((do_map_reg[8*gt+:8] == FO_DSG_CNT) & dsg_hit)
            | ((do_map_reg[8*gt+:8] == FO_LEN_HIT) & len_hit);
        end
      end
    end
  endgenerate

  // reference source selection
  logic signed [15:0] sel_frac;
  always_comb begin
    unique case (ctrl_reg.main_source_select)
      SRC_DIG, SRC_DIG_RET: sel_frac = digf_reg;
      SRC_PULSE: sel_frac = pulse_frac_reg;
      SRC_MULTI: sel_frac = table_reg[mspd_idx];
      SRC_REGUL: sel_frac = unit_b ? reg_unit_b_i : reg_unit_a_i;
      SRC_COMM: sel_frac = commf_reg;
      default: sel_frac = '0;
    endcase
  end

  // fraction times maximum frequency; overflow beyond range saturates
  logic neg_set, want_rev, rev_block;
  logic [16:0] mag_frac;
  logic [32:0] prod;
  logic [15:0] freq_mag;
  assign neg_set = sel_frac < 0;
  assign mag_frac = neg_set ? 17'(-$signed({sel_frac[15], sel_frac})) : {1'b0, sel_frac};
  assign prod = mag_frac * maxf_reg;
  assign freq_mag = (prod[32:30] != 3'h0) ? 16'hffff : prod[29:FRAC_SHIFT];
  assign want_rev = ctrl_reg.rev_cmd | neg_set;
  assign rev_block = ctrl_reg.reverse_inhibit & want_rev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_o <= '0;
    end else begin
      ref_o.outen <= ctrl_reg.run_cmd & ~rev_block;
      ref_o.reverse <= ~rev_block & (want_rev ^ ctrl_reg.direction_invert);
      ref_o.freq <= rev_block ? 16'h0 : freq_mag;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_next = RST_ZERO;
    if (wb_adr_i[7:6] == OFS_TABLE_HI) begin
      rd_next = {16'h0, table_reg[wb_adr_i[5:2]]};
    end else begin
      unique case (wb_adr_i)
        OFS_CTRL: rd_next = {23'h0, ctrl_reg};
        OFS_MAXF: rd_next = {16'h0, maxf_reg};
        OFS_DIGF: rd_next = {16'h0, digf_reg};
        OFS_COMMF: rd_next = {16'h0, commf_reg};
        OFS_CURVE_X: rd_next = curve_x_reg;
        OFS_CURVE_Y: rd_next = curve_y_reg;
        OFS_SET_LEN: rd_next = {16'h0, set_len_reg};
        OFS_PPM: rd_next = {16'h0, ppm_reg};
        OFS_SET_CNT: rd_next = {16'h0, set_cnt_reg};
        OFS_DSG_CNT: rd_next = {16'h0, dsg_cnt_reg};
        OFS_DI_LO: rd_next = di_lo_reg;
        OFS_DI_HI: rd_next = di_hi_reg;
        OFS_DO_MAP: rd_next = do_map_reg;
        OFS_COUNT: rd_next = {16'h0, count_reg};
        OFS_ACT_LEN: rd_next = {16'h0, act_len_reg};
        OFS_STATUS: begin
          rd_next[15:0] = rate_reg;
          rd_next[ST_SET_HIT_BIT] = set_hit;
          rd_next[ST_DSG_HIT_BIT] = dsg_hit;
          rd_next[ST_LEN_HIT_BIT] = len_hit;
          rd_next[ST_REV_BIT] = ref_o.reverse;
          rd_next[ST_OUTEN_BIT] = ref_o.outen;
          rd_next[ST_UNIT_B_BIT] = unit_b;
        end
        OFS_TARGET: rd_next = {16'h0, ref_o.freq};
        default: rd_next = RST_ZERO;
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_wb_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  a_wb_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack after request");
  a_count_halt: assert property (set_hit && !count_wr && !cnt_clr_di && !cnt_clr_sw |=> count_reg == $past(count_reg))
    else $error("count moved after set value");
  a_count_step: assert property (cnt_edge && !set_hit && !count_wr && !cnt_clr_di && !cnt_clr_sw
    |=> count_reg == $past(count_reg) + 16'h1) else $error("count edge lost");
  a_inhibit_zero: assert property (ctrl_reg.reverse_inhibit && want_rev |=> ref_o.freq == 16'h0 && !ref_o.outen)
    else $error("inhibited reverse still drives");
  a_invert_dir: assert property (!rev_block |=> ref_o.reverse == ($past(want_rev) ^ $past(ctrl_reg.direction_invert)))
    else $error("direction sense wrong");
  a_len_output: assert property (len_hit && do_map_reg[23:16] == FO_LEN_HIT |=> digital_output_terminal_o[2])
    else $error("length reached not shown");
  a_len_clear: assert property (len_clr_di || len_clr_sw |=> len_pulses_reg == 32'h0) else $error("length not cleared");
  a_regul_pick: assert property (ctrl_reg.main_source_select == SRC_REGUL |-> sel_frac == (unit_b ? reg_unit_b_i : reg_unit_a_i))
    else $error("regulator not selected");

  c_count_reached: cover property (cnt_edge ##1 set_hit);
  c_length_reached: cover property ($rose(len_hit));
  c_reverse_run: cover property (ref_o.reverse && ref_o.outen);
  c_inhibit_block: cover property (rev_block && ctrl_reg.run_cmd);

endmodule

// *** shared/drc_pkg.sv ***
// shared constants, register map and carrier types for the drive reference and counter block
//
// Overview of operation
// - pulse reference only on pulse terminal, 100 kHz
// - two-point line, 100% equals maximum frequency
// - regulator output used when source code 8
// - two regulator units, auto or terminal switch
// - terminals coded 12..15 select sixteen presets
// - preset table used when source code 6
// - index picks fraction, times maximum frequency
// - unassigned select bits read as zero
// - comm source negative setting runs reverse
// - reverse inhibited: zero hertz, no output
// - reverse inhibit resets to zero
// - direction invert swaps forward and reverse
// - length equals function 27 pulses per meter
// - length output on when length exceeds set
// - function 28 input clears accumulated length
// - length counts up only, pulse terminal only
// - function 25 counts, stops at set value
// - designated value output, counting continues
// - counter runs in run and stop alike
// - count value retained and restored after power; reset here clears it to zero
package drc_pkg;
  localparam int NUM_DI = 8;
  localparam int NUM_DO = 4;
  localparam int PULSE_DI = 4;
  localparam int CLK_HZ = 20000000;
  localparam int RATE_WINDOW_MS = 10;
  localparam int RATE_WINDOW_CYC = CLK_HZ / 1000 * RATE_WINDOW_MS;
  localparam int PULSE_MAX_HZ = 100000;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MAXF = 8'h04;
  localparam logic [7:0] OFS_DIGF = 8'h08;
  localparam logic [7:0] OFS_COMMF = 8'h0c;
  localparam logic [7:0] OFS_CURVE_X = 8'h10;
  localparam logic [7:0] OFS_CURVE_Y = 8'h14;
  localparam logic [7:0] OFS_SET_LEN = 8'h18;
  localparam logic [7:0] OFS_PPM = 8'h1c;
  localparam logic [7:0] OFS_SET_CNT = 8'h20;
  localparam logic [7:0] OFS_DSG_CNT = 8'h24;
  localparam logic [7:0] OFS_DI_LO = 8'h28;
  localparam logic [7:0] OFS_DI_HI = 8'h2c;
  localparam logic [7:0] OFS_DO_MAP = 8'h30;
  localparam logic [7:0] OFS_COUNT = 8'h34;
  localparam logic [7:0] OFS_ACT_LEN = 8'h38;
  localparam logic [7:0] OFS_STATUS = 8'h3c;
  localparam logic [7:0] OFS_TARGET = 8'h40;
  localparam logic [1:0] OFS_TABLE_HI = 2'h2;
  // control word strobe bits (write only)
  localparam int CTRL_CNT_CLR_BIT = 9;
  localparam int CTRL_LEN_CLR_BIT = 10;
  // status word field positions
  localparam int ST_SET_HIT_BIT = 16;
  localparam int ST_DSG_HIT_BIT = 17;
  localparam int ST_LEN_HIT_BIT = 18;
  localparam int ST_REV_BIT = 19;
  localparam int ST_OUTEN_BIT = 20;
  localparam int ST_UNIT_B_BIT = 21;
  // main source codes
  localparam logic [3:0] SRC_DIG = 4'h0;
  localparam logic [3:0] SRC_DIG_RET = 4'h1;
  localparam logic [3:0] SRC_PULSE = 4'h5;
  localparam logic [3:0] SRC_MULTI = 4'h6;
  localparam logic [3:0] SRC_REGUL = 4'h8;
  localparam logic [3:0] SRC_COMM = 4'h9;
  // terminal function codes
  localparam logic [7:0] FN_MSPD0 = 8'h0c;
  localparam logic [7:0] FN_CNT_IN = 8'h19;
  localparam logic [7:0] FN_CNT_CLR = 8'h1a;
  localparam logic [7:0] FN_LEN_IN = 8'h1b;
  localparam logic [7:0] FN_LEN_CLR = 8'h1c;
  localparam logic [7:0] FN_UNIT_SW = 8'h2b;
  localparam logic [7:0] FO_SET_CNT = 8'h08;
  localparam logic [7:0] FO_DSG_CNT = 8'h09;
  localparam logic [7:0] FO_LEN_HIT = 8'h14;
  // fractions are signed with 100% at this value
  localparam logic [15:0] FRAC_ONE = 16'h4000;
  localparam int FRAC_SHIFT = 14;
  // reset values
  localparam logic [15:0] RST_MAXF = 16'h1388;
  localparam logic [15:0] RST_PPM = 16'h0001;
  localparam logic [31:0] RST_CURVE_X = 32'h03e8_0000;
  localparam logic [31:0] RST_CURVE_Y = 32'h4000_0000;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic regulator_auto;
    logic run_cmd;
    logic rev_cmd;
    logic direction_invert;
    logic reverse_inhibit;
    logic [3:0] main_source_select;
  } drc_ctrl_t;

  typedef struct packed {
    logic outen;
    logic reverse;
    logic [15:0] freq;
  } drc_ref_t;

  typedef enum logic [2:0] {
    DV_IDLE = 3'b001,
    DV_RUN = 3'b010,
    DV_STORE = 3'b100
  } drc_div_state_t;
endpackage

// *** verification/drc_pulse_src.sv ***
// partner model: switches and pulse sources on the input terminals
`timescale 1ns/1ns
module drc_pulse_src
  import drc_pkg::*;
(
  input wire logic clk_i,
  output logic [NUM_DI-1:0] level_o
);
  initial level_o = '0;
  // a switch holds its level until moved again
  task automatic set_lvl(input int idx, input logic v);
    @(posedge clk_i);
    level_o[idx] <= v;
  endtask
  // up-only pulses: four clocks high, five low, well above the filter minimum
  task automatic burst(input int idx, input int n);
    repeat (n) begin
      @(posedge clk_i);
      level_o[idx] <= 1'b1;
      repeat (4) @(posedge clk_i);
      level_o[idx] <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    repeat (10) @(posedge clk_i);
  endtask
endmodule

// *** verification/drc_core_tb.sv ***
// self-checking bench for the reference and counter block
`timescale 1ns/1ns
module drc_core_tb;
  import drc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  logic signed [15:0] ua = 16'h0000;
  logic signed [15:0] ub = 16'h0000;
  logic big = 1'b0;
  logic [NUM_DI-1:0] din;
  logic [NUM_DO-1:0] dout;
  drc_ref_t rf;
  int errors = 0;
  int check_count = 0;
  always #25 clk_i = ~clk_i;
  drc_core #(.WINDOW_CYC(100)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .digital_input_terminal_i(din), .reg_unit_a_i(ua), .reg_unit_b_i(ub), .reg_dev_large_i(big),
    .digital_output_terminal_o(dout), .ref_o(rf));
  drc_pulse_src src (.clk_i(clk_i), .level_o(din));
  task automatic results();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; the edge that sees ack high ends it
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hf; wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 50) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
      results();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic t_reset();
    rdc(OFS_MAXF, {16'h0, RST_MAXF});
    rdc(OFS_PPM, {16'h0, RST_PPM});
    rdc(OFS_CTRL, 32'h0);
    rdc(8'h7c, 32'h0);
    $display("reset values done");
  endtask
  task automatic t_count();
    wr(OFS_DI_LO, 32'h000d_0c19);
    wr(OFS_DI_HI, 32'h0000_001b);
    wr(OFS_DO_MAP, 32'h0014_0908);
    wr(OFS_SET_CNT, 32'h5);
    wr(OFS_DSG_CNT, 32'h3);
    src.burst(0, 3);
    chk({30'h0, dout[1:0]}, 32'h2);
    src.burst(0, 2);
    chk({31'h0, dout[0]}, 32'h1);
    src.burst(0, 2);
    rdc(OFS_COUNT, 32'h5);
    chk({31'h0, dout[0]}, 32'h1);
    wr(OFS_CTRL, 32'h200);
    repeat (4) @(posedge clk_i);
    rdc(OFS_COUNT, 32'h0);
    wr(OFS_COUNT, 32'h4);
    rdc(OFS_COUNT, 32'h4);
    wr(OFS_CTRL, 32'h80);
    src.burst(0, 1);
    rdc(OFS_COUNT, 32'h5);
    $display("counter done");
  endtask
  task automatic t_length();
    wr(OFS_PPM, 32'h2);
    wr(OFS_SET_LEN, 32'h2);
    src.burst(4, 4);
    repeat (100) @(posedge clk_i);
    chk({31'h0, dout[2]}, 32'h0);
    src.burst(4, 2);
    repeat (100) @(posedge clk_i);
    rdc(OFS_ACT_LEN, 32'h3);
    chk({31'h0, dout[2]}, 32'h1);
    wr(OFS_CTRL, 32'h400);
    repeat (100) @(posedge clk_i);
    rdc(OFS_ACT_LEN, 32'h0);
    // length code on a plain terminal must not count
    wr(OFS_DI_LO, 32'h000d_1b19);
    src.burst(1, 2);
    repeat (100) @(posedge clk_i);
    rdc(OFS_ACT_LEN, 32'h0);
    wr(OFS_DI_LO, 32'h000d_0c19);
    $display("length done");
  endtask
  task automatic t_multi();
    wr(8'h8c, 32'h2000);
    wr(8'h80, 32'h4000);
    wr(OFS_CTRL, 32'h86);
    src.set_lvl(1, 1'b1);
    src.set_lvl(2, 1'b1);
    repeat (20) @(posedge clk_i);
    chk({14'h0, rf}, 32'h2_09c4);
    wr(8'h8c, 32'he000);
    repeat (20) @(posedge clk_i);
    chk({15'h0, rf.reverse, rf.freq}, 32'h1_09c4);
    wr(OFS_CTRL, 32'h96);
    repeat (20) @(posedge clk_i);
    chk({14'h0, rf}, 32'h0);
    wr(8'h8c, 32'h2000);
    wr(OFS_CTRL, 32'ha6);
    repeat (20) @(posedge clk_i);
    chk({14'h0, rf}, 32'h3_09c4);
    src.set_lvl(1, 1'b0);
    src.set_lvl(2, 1'b0);
    $display("multi-speed done");
  endtask
  task automatic t_regul();
    @(posedge clk_i);
    ua <= 16'sh4000;
    ub <= 16'sh1000;
    wr(OFS_CTRL, 32'h88);
    repeat (20) @(posedge clk_i);
    chk({16'h0, rf.freq}, 32'h1388);
    wr(OFS_CTRL, 32'h188);
    @(posedge clk_i);
    big <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk({16'h0, rf.freq}, 32'h04e2);
    // manual mode: unit switch terminal picks the unit
    wr(OFS_DI_LO, 32'h2b0d_0c19);
    wr(OFS_CTRL, 32'h88);
    repeat (20) @(posedge clk_i);
    chk({16'h0, rf.freq}, 32'h1388);
    src.set_lvl(3, 1'b1);
    repeat (20) @(posedge clk_i);
    chk({16'h0, rf.freq}, 32'h04e2);
    src.set_lvl(3, 1'b0);
    wr(OFS_CTRL, 32'h186);
    repeat (20) @(posedge clk_i);
    chk({16'h0, rf.freq}, 32'h1388);
    $display("regulator done");
  endtask
  // rate at or above x2 clamps to full scale, no pulses falls to y1
  task automatic t_pulse();
    wr(OFS_CURVE_X, 32'h0004_0000);
    wr(OFS_CTRL, 32'h85);
    src.burst(4, 40);
    chk({16'h0, rf.freq}, 32'h1388);
    repeat (300) @(posedge clk_i);
    chk({16'h0, rf.freq}, 32'h0);
    $display("pulse reference done");
  endtask
  task automatic t_comm();
    wr(OFS_COMMF, 32'he000);
    wr(OFS_CTRL, 32'h89);
    repeat (20) @(posedge clk_i);
    chk({14'h0, rf}, 32'h3_09c4);
    $display("comm reference done");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_count();
    t_length();
    t_multi();
    t_regul();
    t_pulse();
    t_comm();
    results();
  end
endmodule
